// File: core/current_monitor_defines.svh
// Register offsets, field layouts, reset values and timing counts.
// Assumes the includer uses a 16-bit signed sample format.
//
// Behaviour
// - Four inputs, each read over two channels
// - Samples are 15-bit magnitude plus sign
// - Four limits; unconfigured range is full span
// - Default limits 3.6, 3.8, 20.5, 21 mA
// - Invalid above fault limit, valid below work
// - Invalid below fault limit, valid above work
// - Deviation beyond tolerance flags value invalid
// - Percent tolerance taken from reference value
// - Absolute, percent or larger-of-both tolerance
// - Overshoot longer than excess time invalidates
// - Overshoots closer than spacing invalidate
// - Linear scaling between two configured points
// - Sum, difference or average of two operands
// - Optional absolute value of arithmetic result
// - Signed configured constant as operand
// - Threshold output for greater or less than
// - Separate switch-on and switch-off thresholds
// - Range output with upper and lower pairs
// - Up to six values forwarded for diagnostics
// - Default diagnostic map inputs to IDs 1-4
// - User map on IDs 1-6 replaces default
`ifndef CURRENT_MONITOR_DEFINES_SVH
`define CURRENT_MONITOR_DEFINES_SVH

// One count is 25 mA / 32767; limits are in counts
`define FULL_SCALE        16'sh7fff
`define LIM_FAULT_LO_RST  16'sh126f
`define LIM_WORK_LO_RST   16'sh1374
`define LIM_WORK_HI_RST   16'sh68f5
`define LIM_FAULT_HI_RST  16'sh6b85

// Register offsets (byte addresses, one word each)
`define A_CTRL       8'h00
`define A_LIM_FLO    8'h04
`define A_LIM_WLO    8'h08
`define A_LIM_WHI    8'h0c
`define A_LIM_FHI    8'h10
`define A_TOL_ABS    8'h14
`define A_TOL_PCT    8'h18
`define A_EXCESS     8'h1c
`define A_SPACING    8'h20
`define A_SC_IN_LO   8'h24
`define A_SC_IN_HI   8'h28
`define A_SC_OUT_LO  8'h2c
`define A_SC_OUT_HI  8'h30
`define A_CONST      8'h34
`define A_THR_ON     8'h38
`define A_THR_OFF    8'h3c
`define A_RNG_HI_ON  8'h40
`define A_RNG_HI_OFF 8'h44
`define A_RNG_LO_ON  8'h48
`define A_RNG_LO_OFF 8'h4c
`define A_DIAG_MAP   8'h50
`define A_STATUS     8'h54
`define A_VALUE0     8'h58
`define A_ARITH      8'h78
`define A_SCALED     8'h7c

// Control field positions
`define C_RANGE_EN   0
`define C_PLAUS_EN   1
`define C_TOL_LO     2
`define C_ARITH_LO   4
`define C_ABS        6
`define C_THR_GT     7
`define C_DIAG_EN    8
`define C_PLAUS_SEL  9
`define C_CTRL_RST   16'h0001

// Default peak timing in microseconds
`define EXCESS_US_RST  16'h000a
`define SPACING_US_RST 16'h0064
`define CLK_MHZ        200

`endif

// File: core/current_monitor_pkg.sv
// Types shared by the current monitor files.
// Assumes the defines header provides all numeric constants.
package current_monitor_pkg;
    typedef enum logic [1:0] {TOL_ABS, TOL_PCT, TOL_BOTH, TOL_RSVD} tol_mode_t;
    typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_AVG, OP_RSVD} arith_op_t;
endpackage

// File: core/work_range_check.sv
// Working range validity with hysteresis for one sample stream.
// Assumes samples are signed counts and limits come from registers.
`timescale 1ns/1ps
`include "current_monitor_defines.svh"
module work_range_check
    import current_monitor_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_reset_n,
    input  wire logic               i_update,
    input  wire logic               i_enable,
    input  wire logic signed [15:0] i_sample,
    input  wire logic signed [15:0] i_fault_lo,
    input  wire logic signed [15:0] i_work_lo,
    input  wire logic signed [15:0] i_work_hi,
    input  wire logic signed [15:0] i_fault_hi,
    output logic                    o_valid
);
    logic valid_reg;

    // Unconfigured range is the whole span, valid for any sample of zero or above
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            valid_reg <= 1'b0;
        end else if (i_update) begin
            if (!i_enable) begin
                valid_reg <= (i_sample >= 16'sh0000);
            end else if (i_sample > i_fault_hi
                         || i_sample < i_fault_lo) begin
                valid_reg <= 1'b0;
            end else if (i_sample < i_work_hi
                         && i_sample > i_work_lo) begin
                valid_reg <= 1'b1;
            end
        end
    end

    assign o_valid = valid_reg;

    a_range_high_invalid: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_update && i_enable && i_sample > i_fault_hi |=> !o_valid)
        else $error("value above fault limit still valid");

    a_range_low_invalid: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_update && i_enable && i_sample < i_fault_lo |=> !o_valid)
        else $error("value below fault limit still valid");

    a_range_hold_band: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_update && i_enable && i_sample >= i_work_hi
        && i_sample <= i_fault_hi |=> o_valid == $past(o_valid))
        else $error("valid changed inside upper hysteresis");
endmodule

// File: core/current_monitor.sv
// Current-loop readout evaluator: validity, plausibility, scaling,
// arithmetic, switching outputs and diagnostic mapping.
// Assumes samples arrive with a one-cycle update strobe per set.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "current_monitor_defines.svh"
module current_monitor
    import current_monitor_pkg::*;
#(
    parameter int N_IN   = 4,
    parameter int N_DIAG = 6
) (
    input  wire logic               i_clk,
    input  wire logic               i_reset_n,
    input  wire logic               i_update,
    input  wire logic [N_IN*16-1:0] i_chan_a,
    input  wire logic [N_IN*16-1:0] i_chan_b,
    input  wire logic [7:0]         i_addr,
    input  wire logic [15:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic [15:0]             o_rdata,
    output logic [N_IN-1:0]         o_valid,
    output logic                    o_thr_out,
    output logic                    o_rng_over,
    output logic                    o_rng_under,
    output logic [N_DIAG*16-1:0]    o_diag_data,
    output logic [N_DIAG-1:0]       o_diag_valid
);
    logic [15:0]        ctrl_reg;
    logic signed [15:0] lim_reg [4];
    logic signed [15:0] tol_abs_reg;
    logic [15:0]        tol_pct_reg;
    logic [15:0]        excess_reg;
    logic [15:0]        spacing_reg;
    logic signed [15:0] sc_reg [4];
    logic signed [15:0] const_reg;
    logic signed [15:0] thr_reg [6];
    logic [3*N_DIAG-1:0] diag_map_reg;
    logic signed [15:0] val_reg [N_IN];
    logic               rvalid [N_IN];
    logic               plaus_ok_reg;
    logic signed [15:0] arith_reg;
    logic signed [15:0] scaled_reg;
    logic               thr_reg_out;
    logic               over_reg;
    logic               under_reg;
    logic [15:0]        rdata_reg;
    logic [31:0]        excess_cnt_reg;
    logic [31:0]        space_cnt_reg;
    logic               seen_reg;
    logic               update_d_reg;

    tol_mode_t          tol_mode;
    arith_op_t          op;
    logic signed [15:0] lead;
    logic signed [15:0] refv;
    logic signed [16:0] dev;
    logic [16:0]        dev_abs;
    logic [16:0]        ref_abs;
    logic [31:0]        pct_prod;
    logic [16:0]        tol_pct;
    logic [16:0]        tol_use;
    logic               over_tol;
    logic [31:0]        excess_cyc;
    logic [31:0]        space_cyc;

    // Two channels of an input are averaged into one reading
    generate
        for (genvar g = 0; g < N_IN; g++) begin : g_in
            logic signed [16:0] sum2;
            assign sum2 = 17'(signed'(i_chan_a[g*16 +: 16]))
                        + 17'(signed'(i_chan_b[g*16 +: 16]));
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    val_reg[g] <= 16'sh0000;
                end else if (i_update) begin
                    val_reg[g] <= sum2[16:1];
                end
            end
            work_range_check u_rng (
                .i_clk      (i_clk),
                .i_reset_n  (i_reset_n),
                .i_update   (update_d_reg),
                .i_enable   (ctrl_reg[`C_RANGE_EN]),
                .i_sample   (val_reg[g]),
                .i_fault_lo (lim_reg[0]),
                .i_work_lo  (lim_reg[1]),
                .i_work_hi  (lim_reg[2]),
                .i_fault_hi (lim_reg[3]),
                .o_valid    (rvalid[g])
            );
            // Pair selected for plausibility takes its check result
            assign o_valid[g] = rvalid[g] && (!ctrl_reg[`C_PLAUS_EN]
                || (g >> 1) != 32'(ctrl_reg[`C_PLAUS_SEL])
                || plaus_ok_reg);
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            update_d_reg <= 1'b0;
        end else begin
            update_d_reg <= i_update;
        end
    end

    // Register writes
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg     <= `C_CTRL_RST;
            lim_reg[0]   <= `LIM_FAULT_LO_RST;
            lim_reg[1]   <= `LIM_WORK_LO_RST;
            lim_reg[2]   <= `LIM_WORK_HI_RST;
            lim_reg[3]   <= `LIM_FAULT_HI_RST;
            tol_abs_reg  <= 16'sh0000;
            tol_pct_reg  <= 16'h0000;
            excess_reg   <= `EXCESS_US_RST;
            spacing_reg  <= `SPACING_US_RST;
            sc_reg[0]    <= 16'sh0000;
            sc_reg[1]    <= `FULL_SCALE;
            sc_reg[2]    <= 16'sh0000;
            sc_reg[3]    <= `FULL_SCALE;
            const_reg    <= 16'sh0000;
            for (int k = 0; k < 6; k++) begin
                thr_reg[k] <= 16'sh0000;
            end
            diag_map_reg <= '0;
        end else if (i_wr) begin
            unique case (i_addr)
                `A_CTRL:       ctrl_reg    <= i_wdata;
                `A_LIM_FLO:    lim_reg[0]  <= i_wdata;
                `A_LIM_WLO:    lim_reg[1]  <= i_wdata;
                `A_LIM_WHI:    lim_reg[2]  <= i_wdata;
                `A_LIM_FHI:    lim_reg[3]  <= i_wdata;
                `A_TOL_ABS:    tol_abs_reg <= i_wdata;
                `A_TOL_PCT:    tol_pct_reg <= i_wdata;
                `A_EXCESS:     excess_reg  <= i_wdata;
                `A_SPACING:    spacing_reg <= i_wdata;
                `A_SC_IN_LO:   sc_reg[0]   <= i_wdata;
                `A_SC_IN_HI:   sc_reg[1]   <= i_wdata;
                `A_SC_OUT_LO:  sc_reg[2]   <= i_wdata;
                `A_SC_OUT_HI:  sc_reg[3]   <= i_wdata;
                `A_CONST:      const_reg   <= i_wdata;
                `A_THR_ON:     thr_reg[0]  <= i_wdata;
                `A_THR_OFF:    thr_reg[1]  <= i_wdata;
                `A_RNG_HI_ON:  thr_reg[2]  <= i_wdata;
                `A_RNG_HI_OFF: thr_reg[3]  <= i_wdata;
                `A_RNG_LO_ON:  thr_reg[4]  <= i_wdata;
                `A_RNG_LO_OFF: thr_reg[5]  <= i_wdata;
                // Map bits beyond the 16-bit word are loaded with ones on a write
                `A_DIAG_MAP:   diag_map_reg <= (3*N_DIAG)'({2'b11, i_wdata});
                default: ;
            endcase
        end
    end

    // Plausibility: lead is the even input of the pair, reference odd
    assign tol_mode = tol_mode_t'(ctrl_reg[`C_TOL_LO +: 2]);
    assign lead     = val_reg[{ctrl_reg[`C_PLAUS_SEL], 1'b0}];
    assign refv     = val_reg[{ctrl_reg[`C_PLAUS_SEL], 1'b1}];
    assign dev      = 17'(lead) - 17'(refv);
    assign dev_abs  = dev[16] ? 17'(-dev) : 17'(dev);
    assign ref_abs  = refv[15] ? 17'(-17'(refv)) : 17'(refv);
    // Percent in hundredths: tol = |ref| * pct / 10000
    assign pct_prod = 32'(ref_abs) * 32'(tol_pct_reg);
    assign tol_pct  = 17'(pct_prod / 32'd10000);

    always_comb begin
        unique case (tol_mode)
            TOL_ABS:  tol_use = 17'(tol_abs_reg);
            TOL_PCT:  tol_use = tol_pct;
            TOL_BOTH: tol_use = (17'(tol_abs_reg) > tol_pct)
                                ? 17'(tol_abs_reg) : tol_pct;
            default:  tol_use = 17'(tol_abs_reg);
        endcase
    end

    assign over_tol   = dev_abs > tol_use;
    assign excess_cyc = 32'(excess_reg) * `CLK_MHZ;
    assign space_cyc  = 32'(spacing_reg) * `CLK_MHZ;

    // Peak excess timer and spacing timer between overshoots
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            excess_cnt_reg <= '0;
            space_cnt_reg  <= '0;
            seen_reg       <= 1'b0;
            plaus_ok_reg   <= 1'b1;
        end else if (!ctrl_reg[`C_PLAUS_EN]) begin
            excess_cnt_reg <= '0;
            seen_reg       <= 1'b0;
            plaus_ok_reg   <= 1'b1;
        end else if (over_tol) begin
            excess_cnt_reg <= excess_cnt_reg + 32'd1;
            if (excess_cnt_reg == 32'd0 && seen_reg
                && space_cnt_reg < space_cyc) begin
                plaus_ok_reg <= 1'b0;
            end else if (excess_cnt_reg >= excess_cyc) begin
                plaus_ok_reg <= 1'b0;
            end
            if (excess_cnt_reg == 32'd0) begin
                space_cnt_reg <= '0;
                seen_reg      <= 1'b1;
            end
        end else begin
            excess_cnt_reg <= '0;
            if (space_cnt_reg != 32'hffffffff) begin
                space_cnt_reg <= space_cnt_reg + 32'd1;
            end
            if (space_cnt_reg >= space_cyc) begin
                plaus_ok_reg <= 1'b1;
            end
        end
    end

    // Arithmetic on input 0 and the constant; scaling of input 0
    assign op = arith_op_t'(ctrl_reg[`C_ARITH_LO +: 2]);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        logic signed [16:0] r;
        logic signed [31:0] num;
        logic signed [16:0] span;
        if (!i_reset_n) begin
            arith_reg  <= 16'sh0000;
            scaled_reg <= 16'sh0000;
        end else begin
            unique case (op)
                OP_ADD:  r = 17'(val_reg[0]) + 17'(const_reg);
                OP_SUB:  r = 17'(val_reg[0]) - 17'(const_reg);
                OP_AVG:  r = (17'(val_reg[0]) + 17'(const_reg)) >>> 1;
                default: r = 17'(val_reg[0]);
            endcase
            if (ctrl_reg[`C_ABS] && r[16]) begin
                r = -r;
            end
            arith_reg <= r[15:0];
            span = 17'(sc_reg[1]) - 17'(sc_reg[0]);
            num  = 32'(17'(val_reg[0]) - 17'(sc_reg[0]))
                 * 32'(17'(sc_reg[3]) - 17'(sc_reg[2]));
            if (span != 17'sh00000) begin
                scaled_reg <= 16'((num / 32'(span))
                                  + 32'(sc_reg[2]));
            end
        end
    end

    // Switching outputs with on/off hysteresis
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            thr_reg_out <= 1'b0;
            over_reg    <= 1'b0;
            under_reg   <= 1'b0;
        end else if (update_d_reg) begin
            if (ctrl_reg[`C_THR_GT]) begin
                if (scaled_reg > thr_reg[0]) thr_reg_out <= 1'b1;
                else if (scaled_reg < thr_reg[1]) thr_reg_out <= 1'b0;
            end else begin
                if (scaled_reg < thr_reg[0]) thr_reg_out <= 1'b1;
                else if (scaled_reg > thr_reg[1]) thr_reg_out <= 1'b0;
            end
            if (scaled_reg > thr_reg[2]) over_reg <= 1'b1;
            else if (scaled_reg < thr_reg[3]) over_reg <= 1'b0;
            if (scaled_reg < thr_reg[4]) under_reg <= 1'b1;
            else if (scaled_reg > thr_reg[5]) under_reg <= 1'b0;
        end
    end

    assign o_thr_out   = thr_reg_out;
    assign o_rng_over  = over_reg;
    assign o_rng_under = under_reg;

    // Diagnostic slots: source codes 0-3 inputs, 4 scaled, 5 arith,
    // 6 constant, 7 unused
    generate
        for (genvar d = 0; d < N_DIAG; d++) begin : g_diag
            logic [2:0] src;
            assign src = ctrl_reg[`C_DIAG_EN] ? diag_map_reg[d*3 +: 3]
                       : (d < N_IN ? 3'(d) : 3'h7);
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    o_diag_data[d*16 +: 16] <= 16'h0000;
                    o_diag_valid[d]         <= 1'b0;
                end else begin
                    o_diag_valid[d] <= (src != 3'h7);
                    unique case (src)
                        3'h0, 3'h1, 3'h2, 3'h3:
                            o_diag_data[d*16 +: 16] <= val_reg[src[1:0]];
                        3'h4: o_diag_data[d*16 +: 16] <= scaled_reg;
                        3'h5: o_diag_data[d*16 +: 16] <= arith_reg;
                        3'h6: o_diag_data[d*16 +: 16] <= const_reg;
                        default: o_diag_data[d*16 +: 16] <= 16'h0000;
                    endcase
                end
            end
        end
    endgenerate

    // Read port, data valid the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_reg <= 16'h0000;
        end else if (i_rd) begin
            if (i_addr >= `A_VALUE0 && i_addr < `A_VALUE0 + 8'h10) begin
                rdata_reg <= val_reg[i_addr[3:2] + 2'h2];
            end else begin
                unique case (i_addr)
                    `A_CTRL:    rdata_reg <= ctrl_reg;
                    `A_LIM_FLO: rdata_reg <= lim_reg[0];
                    `A_LIM_WLO: rdata_reg <= lim_reg[1];
                    `A_LIM_WHI: rdata_reg <= lim_reg[2];
                    `A_LIM_FHI: rdata_reg <= lim_reg[3];
                    `A_STATUS:  rdata_reg <= {8'h00, plaus_ok_reg,
                                   under_reg, over_reg, thr_reg_out,
                                   rvalid[3], rvalid[2], rvalid[1],
                                   rvalid[0]};
                    `A_ARITH:   rdata_reg <= arith_reg;
                    `A_SCALED:  rdata_reg <= scaled_reg;
                    `A_CONST:   rdata_reg <= const_reg;
                    `A_TOL_ABS: rdata_reg <= tol_abs_reg;
                    default:    rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    assign o_rdata = rdata_reg;

    sequence s_excess_run;
        ctrl_reg[`C_PLAUS_EN] && over_tol
        && excess_cnt_reg >= excess_cyc;
    endsequence

    a_plaus_disabled_ok: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !ctrl_reg[`C_PLAUS_EN] |=> plaus_ok_reg)
        else $error("plausibility fail while disabled");

    a_peak_excess: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        s_excess_run |=> !plaus_ok_reg)
        else $error("long overshoot not flagged");

    a_tol_larger: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        tol_mode == TOL_BOTH |-> tol_use >= tol_pct
        && tol_use >= 17'(tol_abs_reg))
        else $error("combined tolerance not the larger");

    a_abs_result: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        ctrl_reg[`C_ABS] && $stable(ctrl_reg) |=> !arith_reg[15]
        || arith_reg == 16'sh8000)
        else $error("absolute result negative");

    a_default_diag: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !ctrl_reg[`C_DIAG_EN] |=> o_diag_data[15:0] == $past(val_reg[0]))
        else $error("default diagnostic slot 1 wrong");

    a_range_over_on: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        update_d_reg && scaled_reg > thr_reg[2] |=> o_rng_over)
        else $error("range over not switched on");

    a_valid_and: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !rvalid[0] |-> !o_valid[0])
        else $error("valid without working range");
endmodule

// File: sim/sensor_pair_model.sv
// Sensor pair model: four current loops, each read over two channels.
// Assumes the bench sets one level per input; a new set every 4 clocks.
`timescale 1ns/1ps
module sensor_pair_model (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [63:0] i_level,
    output logic [63:0]      o_chan_a,
    output logic [63:0]      o_chan_b,
    output logic             o_update
);
    logic [1:0] div_reg;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_reg  <= 2'h0;
            o_update <= 1'b0;
            o_chan_a <= 64'h0;
            o_chan_b <= 64'h0;
        end else begin
            div_reg  <= div_reg + 2'h1;
            o_update <= (div_reg == 2'h3);
            // Channels straddle the level so only their mean is exact
            for (int g = 0; g < 4; g++) begin
                o_chan_a[g*16+:16] <= i_level[g*16+:16] + 16'h0001;
                o_chan_b[g*16+:16] <= i_level[g*16+:16] - 16'h0001;
            end
        end
    end
endmodule

// File: sim/current_monitor_bench.sv
// Self-checking bench for the current monitor.
// Assumes the sensor pair model feeds the sample ports.
`timescale 1ns/1ps
`include "current_monitor_defines.svh"
module current_monitor_bench;
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [63:0] level = 64'h0;
    logic [63:0] chan_a, chan_b;
    logic        update, o_thr_out, o_rng_over, o_rng_under;
    logic [15:0] o_rdata;
    logic [3:0]  o_valid;
    logic [95:0] o_diag_data;
    logic [5:0]  o_diag_valid;
    int          n_errors = 0;
    int          tests_run = 0;
    logic [7:0]  cf_a [15] = '{`A_SC_IN_LO, `A_SC_IN_HI, `A_SC_OUT_LO,
        `A_SC_OUT_HI, `A_THR_ON, `A_THR_OFF, `A_RNG_HI_ON, `A_RNG_HI_OFF,
        `A_RNG_LO_ON, `A_RNG_LO_OFF, `A_TOL_ABS, `A_TOL_PCT, `A_EXCESS,
        `A_SPACING, `A_CTRL};
    logic [15:0] cf_d [15] = '{16'h0000, 16'h7fff, 16'h0000, 16'h7fff,
        16'h3000, 16'h2000, 16'h6000, 16'h5800, 16'h1800, 16'h2000,
        16'h0100, 16'h03e8, 16'h0001, 16'h0002, 16'h0081};
    logic [15:0] rs [13] = '{16'h2800, 16'h3100, 16'h2800, 16'h6a00,
        16'h6c00, 16'h6a00, 16'h5c00, 16'h1f00, 16'h1300, 16'h1200,
        16'h1300, 16'h1c00, 16'h2100};
    logic [3:0]  re [13] = '{4'h8, 4'hc, 4'hc, 4'he, 4'h6, 4'h6, 4'he,
        4'h8, 4'h9, 4'h1, 4'h1, 4'h9, 4'h8};
    logic [15:0] ar_c [4] = '{16'hff00, 16'hff00, 16'hff00, 16'hf000};
    logic [15:0] ar_i [4] = '{16'h2000, 16'h2000, 16'h2000, 16'h0100};
    logic [15:0] ar_e [4] = '{16'h1f00, 16'h2100, 16'h0f80, 16'h0f00};
    logic [15:0] p0 [12] = '{16'h3000, 16'h3200, 16'h3000, 16'h3200,
        16'h3000, 16'h3200, 16'h3000, 16'h3200, 16'h3000, 16'h2360,
        16'h2000, 16'h2300};
    int          pn [12] = '{20, 40, 500, 300, 600, 40, 40, 40, 600, 300,
        600, 300};
    logic        pe [12] = '{1, 1, 1, 0, 1, 1, 1, 0, 1, 0, 1, 1};

    always #2.5 i_clk = ~i_clk;

    sensor_pair_model model_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_level(level), .o_chan_a(chan_a), .o_chan_b(chan_b),
        .o_update(update));
    current_monitor dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_update(update), .i_chan_a(chan_a), .i_chan_b(chan_b),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_valid(o_valid), .o_thr_out(o_thr_out),
        .o_rng_over(o_rng_over), .o_rng_under(o_rng_under),
        .o_diag_data(o_diag_data), .o_diag_valid(o_diag_valid));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 check(o_rdata, exp);
    endtask
    // Sets inputs 0 and 1, then waits so outputs settle
    task automatic hold(input logic [15:0] v0, v1, input int n);
        @(posedge i_clk);
        level[31:0] <= {v1, v0};
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic complete_run;
        if (n_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(`A_CTRL, `C_CTRL_RST);
        rd(`A_LIM_FLO, `LIM_FAULT_LO_RST);
        rd(`A_LIM_WLO, `LIM_WORK_LO_RST);
        rd(`A_LIM_WHI, `LIM_WORK_HI_RST);
        rd(`A_LIM_FHI, `LIM_FAULT_HI_RST);
        wr(8'hf0, 16'h1234);
        rd(8'hf0, 16'h0000);
        level[63:32] <= 32'h4400_3300;
        hold(16'h1100, 16'h2200, 12);
        for (int k = 0; k < 4; k++) begin
            check(o_diag_data[k*16+:16], level[k*16+:16]);
        end
        check(16'(o_diag_valid), 16'h000f);
        rd(`A_VALUE0 + 8'h04, 16'h2200);
        for (int k = 0; k < 4; k++) begin
            wr(cf_a[k], k == 1 ? 16'h5000 : k == 3 ? 16'h4000 :
                k == 0 ? 16'h1000 : 16'h0000);
        end
        hold(16'h3000, 16'h3000, 12);
        rd(`A_SCALED, 16'h2000);
        for (int k = 0; k < 4; k++) begin
            wr(`A_CONST, ar_c[k]);
            wr(`A_CTRL, 16'h0001 | (16'(k % 3) << 4) | (16'(k == 3) << 6));
            hold(ar_i[k], 16'h3000, 12);
            rd(`A_ARITH, ar_e[k]);
        end
        rd(`A_CONST, 16'hf000);
        for (int k = 0; k < 15; k++) wr(cf_a[k], cf_d[k]);
        for (int k = 0; k < 13; k++) begin
            hold(rs[k], 16'h3000, 12);
            check({o_valid[0], o_thr_out, o_rng_over, o_rng_under},
                16'(re[k]));
        end
        wr(`A_CTRL, 16'h0000);
        // Pair agrees here so no overshoot is seen when checking starts
        hold(16'h7000, 16'h7000, 12);
        check(16'(o_valid[0]), 16'h0001);
        for (int k = 0; k < 12; k++) begin
            wr(`A_CTRL, k < 9 ? 16'h0003 : k < 11 ? 16'h0007 : 16'h000b);
            hold(p0[k], k < 9 ? 16'h3000 : 16'h2000, pn[k]);
            check(16'(o_valid[0]), 16'(pe[k]));
        end
        wr(`A_CONST, 16'h0abc);
        wr(`A_DIAG_MAP, 16'h7ff3);
        wr(`A_CTRL, 16'h0101);
        hold(16'h3000, 16'h3000, 12);
        check(o_diag_data[15:0], 16'h4400);
        check(o_diag_data[31:16], 16'h0abc);
        check(16'(o_diag_valid[4:0]), 16'h0003);
        rd(`A_STATUS, 16'h008f);
        complete_run();
    end
endmodule
